// ===== rtl/iatc_ctrl.sv
`timescale 1ns/10ps
// Function
// - Two selectable schemes; legacy lacks burst trigger
// - Legacy per-frame trigger acts as frame start
// - Legacy scheme active after reset
// - Host switches scheme; device applies it
// - No frame before a start command
// - Single mode: one frame, then start lapses
// - Continuous mode: frames until stop command
// - After stop, nothing until a new start
// - Burst trigger off: burst enable made internally
// - Burst trigger on: begin waiting for it
// - Burst wait ignores per-frame triggers
// - Burst trigger moves to frame wait
// - Count frames; at frame count, back to burst wait
// - Frame trigger starts frame; re-wait when ready
// - Frame trigger off: internal at configured rate
// - Frame trigger on: each accepted trigger exposes
// - Frame triggers outside frame wait are dropped
// - Stop mid-frame finishes it; else immediate
// - Source per trigger: software or line 1
// - Mode and source writes hit selected trigger
module iatc_ctrl #(
    parameter int CNT_W = iatc_pkg::CNT_W,
    parameter int PER_W = iatc_pkg::PER_W
) (
    input  wire logic                     sys_clk,               // Camera clock, 250 MHz
    input  wire logic                     rstn,                  // Asynchronous reset, active low
    input  wire logic                     acq_start_cmd,         // Acquisition start command pulse
    input  wire logic                     acq_stop_cmd,          // Acquisition stop command pulse
    input  wire iatc_pkg::iatc_acq_mode_e acq_mode,              // Single frame or continuous
    input  wire logic                     scheme_we,             // Write strobe for the scheme
    input  wire iatc_pkg::iatc_scheme_e   control_scheme_select, // New control scheme
    input  wire iatc_pkg::iatc_sel_e      trig_sel,              // Trigger type addressed
    input  wire logic                     trig_cfg_we,           // Write strobe for trigger settings
    input  wire iatc_pkg::iatc_trig_cfg_s trig_cfg_wdata,        // Mode and source to write
    input  wire logic                     sw_trig_cmd,           // Software trigger pulse
    input  wire logic                     line1_in,              // Hardware input line 1
    input  wire logic [CNT_W-1:0]         frame_count,           // Frames per burst
    input  wire logic [PER_W-1:0]         frame_period,          // Internal trigger period, cycles
    input  wire logic                     frame_done,            // Readout ready for next trigger
    output logic                          frame_start,           // One cycle: begin exposure
    output logic                          frame_trig_drop,       // One cycle: trigger ignored
    output iatc_pkg::iatc_state_e         acq_status,            // Current acquisition status
    output logic [CNT_W-1:0]              frame_cnt,             // Frames taken in this burst
    output iatc_pkg::iatc_scheme_e        scheme_active          // Scheme in force
);
    ////////////////////////////////////////////////////////////////////////////
    // State
    iatc_pkg::iatc_state_e    state_reg;
    iatc_pkg::iatc_state_e    state_next;
    iatc_pkg::iatc_scheme_e   scheme_reg;
    iatc_pkg::iatc_scheme_e   scheme_next;
    iatc_pkg::iatc_trig_cfg_s acq_cfg_reg;
    iatc_pkg::iatc_trig_cfg_s acq_cfg_next;
    iatc_pkg::iatc_trig_cfg_s frm_cfg_reg;
    iatc_pkg::iatc_trig_cfg_s frm_cfg_next;
    logic [CNT_W-1:0]         cnt_reg;
    logic [CNT_W-1:0]         cnt_next;
    logic [PER_W-1:0]         rate_reg;
    logic [PER_W-1:0]         rate_next;
    logic                     stop_pend_reg;
    logic                     stop_pend_next;
    logic                     fs_reg;
    logic                     fs_next;
    logic                     drop_reg;
    logic                     drop_next;

    logic line_rise;
    logic is_std;
    logic acq_gate;
    logic sw_acq;
    logic sw_frm;
    logic acq_evt;
    logic int_tick;
    logic frm_evt;
    logic burst_end;

    ////////////////////////////////////////////////////////////////////////////
    // Line 1 passes two flip-flops before any use
    iatc_sync_edge u_line1 (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .pin_in     (line1_in),
        .rise_pulse (line_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Trigger sources
    assign is_std    = (scheme_reg == iatc_pkg::IATC_STANDARD);
    assign acq_gate  = is_std && acq_cfg_reg.mode_on;
    assign sw_acq    = sw_trig_cmd && is_std && (trig_sel == iatc_pkg::IATC_SEL_ACQ);
    assign sw_frm    = sw_trig_cmd && (!is_std || (trig_sel == iatc_pkg::IATC_SEL_FRAME));
    assign acq_evt   = (acq_cfg_reg.src == iatc_pkg::IATC_SRC_LINE1) ? line_rise : sw_acq;
    // Internal ticks landing outside frame wait are lost
    assign int_tick  = (state_reg != iatc_pkg::IATC_IDLE) && (rate_reg >= frame_period - 1'b1);
    assign frm_evt   = !frm_cfg_reg.mode_on ? int_tick :
                       ((frm_cfg_reg.src == iatc_pkg::IATC_SRC_LINE1) ? line_rise : sw_frm);
    assign burst_end = acq_gate && (cnt_reg == frame_count);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration next values
    always_comb begin
        scheme_next  = scheme_reg;
        acq_cfg_next = acq_cfg_reg;
        frm_cfg_next = frm_cfg_reg;
        if (scheme_we) begin
            scheme_next = control_scheme_select;
        end
        // In legacy the acquisition selector names the per-frame trigger
        if (trig_cfg_we) begin
            if (is_std && (trig_sel == iatc_pkg::IATC_SEL_ACQ)) begin
                acq_cfg_next = trig_cfg_wdata;
            end else begin
                frm_cfg_next = trig_cfg_wdata;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scheme_reg  <= iatc_pkg::SCHEME_RST;
            acq_cfg_reg <= iatc_pkg::TRIG_RST;
            frm_cfg_reg <= iatc_pkg::TRIG_RST;
        end else begin
            scheme_reg  <= scheme_next;
            acq_cfg_reg <= acq_cfg_next;
            frm_cfg_reg <= frm_cfg_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acquisition state machine next values
    always_comb begin
        state_next     = state_reg;
        cnt_next       = cnt_reg;
        stop_pend_next = stop_pend_reg;
        fs_next        = 1'b0;
        drop_next      = 1'b0;
        rate_next      = (state_reg == iatc_pkg::IATC_IDLE || int_tick) ? '0 : rate_reg + 1'b1;
        // External frame triggers outside frame wait are reported and lost
        if (frm_evt && frm_cfg_reg.mode_on && state_reg != iatc_pkg::IATC_WAIT_FRAME) begin
            drop_next = 1'b1;
        end
        case (state_reg)
            iatc_pkg::IATC_IDLE: begin
                stop_pend_next = 1'b0;
                if (acq_start_cmd && !acq_stop_cmd) begin
                    cnt_next   = '0;
                    state_next = acq_gate ? iatc_pkg::IATC_WAIT_ACQ
                                          : iatc_pkg::IATC_WAIT_FRAME;
                end
            end
            iatc_pkg::IATC_WAIT_ACQ: begin
                if (acq_stop_cmd) begin
                    state_next = iatc_pkg::IATC_IDLE;
                end else if (!acq_gate || acq_evt) begin
                    cnt_next   = '0;
                    state_next = iatc_pkg::IATC_WAIT_FRAME;
                end
            end
            iatc_pkg::IATC_WAIT_FRAME: begin
                if (acq_stop_cmd) begin
                    state_next = iatc_pkg::IATC_IDLE;
                end else if (frm_evt) begin
                    fs_next    = 1'b1;
                    cnt_next   = cnt_reg + 1'b1;
                    state_next = iatc_pkg::IATC_FRAME;
                end
            end
            iatc_pkg::IATC_FRAME: begin
                // A stop seen mid-frame waits for readout to end
                if (acq_stop_cmd) begin
                    stop_pend_next = 1'b1;
                end
                if (frame_done) begin
                    if (acq_stop_cmd || stop_pend_reg || acq_mode == iatc_pkg::IATC_SINGLE) begin
                        state_next = iatc_pkg::IATC_IDLE;
                    end else if (burst_end) begin
                        cnt_next   = '0;
                        state_next = iatc_pkg::IATC_WAIT_ACQ;
                    end else begin
                        state_next = iatc_pkg::IATC_WAIT_FRAME;
                    end
                end
            end
            default: begin
                state_next = iatc_pkg::IATC_IDLE;
            end
        endcase
    end

    // Acquisition state registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg     <= iatc_pkg::IATC_IDLE;
            cnt_reg       <= '0;
            rate_reg      <= '0;
            stop_pend_reg <= 1'b0;
            fs_reg        <= 1'b0;
            drop_reg      <= 1'b0;
        end else begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            rate_reg      <= rate_next;
            stop_pend_reg <= stop_pend_next;
            fs_reg        <= fs_next;
            drop_reg      <= drop_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign frame_start     = fs_reg;
    assign frame_trig_drop = drop_reg;
    assign acq_status      = state_reg;
    assign frame_cnt       = cnt_reg;
    assign scheme_active   = scheme_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    // All checks sleep while reset is low
    default disable iff (!rstn);

    AST_START_ONLY_FROM_WAIT: assert property (
        frame_start |-> $past(state_reg) == iatc_pkg::IATC_WAIT_FRAME && state_reg == iatc_pkg::IATC_FRAME)
        else $error("frame start without frame wait");

    AST_SINGLE_LAPSE: assert property (
        state_reg == iatc_pkg::IATC_FRAME && frame_done && acq_mode == iatc_pkg::IATC_SINGLE
        |=> state_reg == iatc_pkg::IATC_IDLE && !frame_start ##1 !frame_start)
        else $error("single frame mode did not lapse");

    AST_CONT_HOLD: assert property (
        state_reg == iatc_pkg::IATC_FRAME && frame_done && acq_mode == iatc_pkg::IATC_CONTINUOUS
        && !acq_stop_cmd && !stop_pend_reg && !burst_end |=> state_reg == iatc_pkg::IATC_WAIT_FRAME)
        else $error("continuous mode lost arming");

    AST_STOP_IDLE: assert property (
        acq_stop_cmd && (state_reg == iatc_pkg::IATC_WAIT_FRAME || state_reg == iatc_pkg::IATC_WAIT_ACQ)
        |=> state_reg == iatc_pkg::IATC_IDLE && !frame_start)
        else $error("stop not immediate when no frame");

    AST_STOP_FINISH: assert property (
        acq_stop_cmd && state_reg == iatc_pkg::IATC_FRAME && !frame_done
        |=> state_reg == iatc_pkg::IATC_FRAME && stop_pend_reg)
        else $error("frame in progress cut short by stop");

    AST_STOP_AFTER_FRAME: assert property (
        stop_pend_reg && state_reg == iatc_pkg::IATC_FRAME && frame_done
        |=> state_reg == iatc_pkg::IATC_IDLE && !frame_start)
        else $error("stop not applied after frame");

    AST_BURST_BLOCK: assert property (
        state_reg == iatc_pkg::IATC_WAIT_ACQ |=> !frame_start)
        else $error("frame started during burst wait");

    AST_BURST_ENTER: assert property (
        state_reg == iatc_pkg::IATC_WAIT_ACQ && acq_evt && !acq_stop_cmd
        |=> state_reg == iatc_pkg::IATC_WAIT_FRAME && cnt_reg == '0)
        else $error("burst trigger not honoured");

    AST_BURST_END: assert property (
        state_reg == iatc_pkg::IATC_FRAME && frame_done && burst_end && !acq_stop_cmd && !stop_pend_reg
        && acq_mode == iatc_pkg::IATC_CONTINUOUS |=> state_reg == iatc_pkg::IATC_WAIT_ACQ)
        else $error("burst did not end at frame count");

    AST_DROP_REPORT: assert property (
        frm_evt && frm_cfg_reg.mode_on && state_reg != iatc_pkg::IATC_WAIT_FRAME
        |=> frame_trig_drop && !frame_start)
        else $error("ignored trigger not reported");

    AST_NO_GATE_START: assert property (
        state_reg == iatc_pkg::IATC_IDLE && acq_start_cmd && !acq_stop_cmd && !acq_gate
        |=> state_reg == iatc_pkg::IATC_WAIT_FRAME)
        else $error("internal burst enable missing");

    // Scheme, configuration, trigger source, frame start, frame count and state transition checks
    AST_LEGACY_NO_BURST: assert property (
        state_reg == iatc_pkg::IATC_WAIT_ACQ
        |-> $past(scheme_reg) == iatc_pkg::IATC_STANDARD)
        else $error("burst wait in legacy scheme");

    AST_LEGACY_FRAME: assert property (
        !is_std && state_reg == iatc_pkg::IATC_WAIT_FRAME && sw_trig_cmd && !acq_stop_cmd
        && frm_cfg_reg.mode_on && frm_cfg_reg.src == iatc_pkg::IATC_SRC_SOFTWARE |=> frame_start)
        else $error("legacy trigger did not start a frame");

    AST_SCHEME_APPLY: assert property (
        scheme_we |=> scheme_active == $past(control_scheme_select))
        else $error("scheme write not applied");

    AST_IDLE_HOLD: assert property (
        state_reg == iatc_pkg::IATC_IDLE && !acq_start_cmd
        |=> state_reg == iatc_pkg::IATC_IDLE)
        else $error("left idle without start");

    AST_BURST_WAIT: assert property (
        state_reg == iatc_pkg::IATC_IDLE && acq_start_cmd && !acq_stop_cmd && acq_gate
        |=> state_reg == iatc_pkg::IATC_WAIT_ACQ)
        else $error("no burst wait with burst trigger on");

    AST_FRAME_COUNT: assert property (
        frame_start
        |-> frame_cnt == $past(frame_cnt) + 1'b1)
        else $error("frame count not advanced");

    AST_FRAME_HOLD: assert property (
        state_reg == iatc_pkg::IATC_FRAME && !frame_done
        |=> state_reg == iatc_pkg::IATC_FRAME)
        else $error("frame left before readout end");

    AST_INT_START: assert property (
        !frm_cfg_reg.mode_on && int_tick && state_reg == iatc_pkg::IATC_WAIT_FRAME && !acq_stop_cmd
        |=> frame_start)
        else $error("internal frame trigger lost");

    AST_EXT_START: assert property (
        frm_cfg_reg.mode_on && frm_evt && state_reg == iatc_pkg::IATC_WAIT_FRAME && !acq_stop_cmd
        |=> frame_start && !frame_trig_drop)
        else $error("accepted trigger did not start a frame");

    AST_SRC_SELECT: assert property (
        state_reg == iatc_pkg::IATC_WAIT_ACQ && acq_gate && acq_cfg_reg.src == iatc_pkg::IATC_SRC_SOFTWARE
        && !sw_trig_cmd && !acq_stop_cmd |=> state_reg == iatc_pkg::IATC_WAIT_ACQ)
        else $error("burst wait left without its trigger");

    AST_CFG_TARGET: assert property (
        trig_cfg_we && is_std && trig_sel == iatc_pkg::IATC_SEL_FRAME
        |=> frm_cfg_reg == $past(trig_cfg_wdata) && acq_cfg_reg == $past(acq_cfg_reg))
        else $error("trigger setting hit the other trigger");

    // Main scenarios
    COV_SINGLE: cover property (frame_start ##[1:50] state_reg == iatc_pkg::IATC_IDLE);
    COV_INT_FRAME: cover property (!frm_cfg_reg.mode_on && frame_start);
    COV_BURST: cover property (state_reg == iatc_pkg::IATC_FRAME ##1 state_reg == iatc_pkg::IATC_WAIT_ACQ);
    COV_STOP_MID: cover property (acq_stop_cmd && state_reg == iatc_pkg::IATC_FRAME);
    COV_DROP: cover property (frame_trig_drop);
endmodule

// ===== rtl/iatc_pkg.sv
package iatc_pkg;

    // Control scheme, acquisition mode, trigger selection and source
    typedef enum logic { IATC_LEGACY, IATC_STANDARD } iatc_scheme_e;
    typedef enum logic { IATC_SINGLE, IATC_CONTINUOUS } iatc_acq_mode_e;
    typedef enum logic { IATC_SEL_ACQ, IATC_SEL_FRAME } iatc_sel_e;
    typedef enum logic { IATC_SRC_SOFTWARE, IATC_SRC_LINE1 } iatc_src_e;

    // Acquisition status
    typedef enum logic [1:0] {
        IATC_IDLE,
        IATC_WAIT_ACQ,
        IATC_WAIT_FRAME,
        IATC_FRAME
    } iatc_state_e;

    // Settings held per trigger type
    typedef struct packed {
        logic      mode_on;
        iatc_src_e src;
    } iatc_trig_cfg_s;

    // Widths of the frame counter and the internal frame period
    localparam int CNT_W = 16;
    localparam int PER_W = 24;

    // Reset values
    localparam iatc_scheme_e   SCHEME_RST = IATC_LEGACY;
    localparam iatc_trig_cfg_s TRIG_RST   = '{mode_on: 1'b0, src: IATC_SRC_LINE1};

endpackage

// ===== rtl/iatc_sync_edge.sv
`timescale 1ns/10ps
// Two-stage synchroniser for the trigger pin with a rising edge detector
module iatc_sync_edge (
    input  wire logic sys_clk,    // Camera clock
    input  wire logic rstn,       // Asynchronous reset, active low
    input  wire logic pin_in,     // Raw input line
    output logic      rise_pulse  // One cycle on each rising edge
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic s1_next;
    logic s2_next;
    logic s3_next;

    // Shift the pin through the stages; s2 and s3 feed the detector
    always_comb begin
        s1_next = pin_in;
        s2_next = s1_reg;
        s3_next = s2_reg;
    end

    // Stage registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
        end
    end

    // Edge of the synchronised level
    assign rise_pulse = s2_reg & ~s3_reg;
endmodule

// ===== sim/iatc_partner.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Far side: readout that reports frame completion, and a line 1 trigger source
module iatc_partner #(
    parameter int DONE_DLY = 3
) (
    input  wire logic sys_clk,    // Camera clock
    input  wire logic rstn,       // Asynchronous reset, active low
    input  wire logic frame_start, // Exposure begins
    input  wire logic line_fire,  // Bench asks for one line pulse
    output logic      frame_done, // One cycle: readout finished
    output logic      line1_in    // Hardware trigger line
);
    logic [7:0] done_cnt_reg;
    logic [3:0] line_cnt_reg;

    // Readout delay and line pulse shaping; the pulse is four cycles high, then
    // the line stays low until line_fire asks for the next pulse
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            done_cnt_reg <= 8'h00;
            line_cnt_reg <= 4'h0;
            frame_done   <= 1'b0;
            line1_in     <= 1'b0;
        end else begin
            frame_done <= (done_cnt_reg == 8'h01);
            if (frame_start) begin
                done_cnt_reg <= 8'(DONE_DLY);
            end else if (done_cnt_reg != 8'h00) begin
                done_cnt_reg <= done_cnt_reg - 8'h01;
            end
            if (line_fire) begin
                line_cnt_reg <= 4'h6;
            end else if (line_cnt_reg != 4'h0) begin
                line_cnt_reg <= line_cnt_reg - 4'h1;
            end
            line1_in <= (line_cnt_reg > 4'h2);
        end
    end
endmodule

// ===== sim/tb.sv
`timescale 1ns/10ps
module tb;
    logic                            sys_clk = 1'b0;
    logic                            rstn = 1'b0;
    logic                            acq_start_cmd = 1'b0;
    logic                            acq_stop_cmd = 1'b0;
    iatc_pkg::iatc_acq_mode_e        acq_mode = iatc_pkg::IATC_SINGLE;
    logic                            scheme_we = 1'b0;
    iatc_pkg::iatc_scheme_e          scheme_sel = iatc_pkg::IATC_LEGACY;
    iatc_pkg::iatc_sel_e             trig_sel = iatc_pkg::IATC_SEL_FRAME;
    logic                            trig_cfg_we = 1'b0;
    iatc_pkg::iatc_trig_cfg_s        trig_cfg_wdata = '0;
    logic                            sw_trig_cmd = 1'b0;
    logic                            line1_in;
    logic                            line_fire = 1'b0;
    logic [iatc_pkg::CNT_W-1:0]      frame_count = 16'h0002;
    logic [iatc_pkg::PER_W-1:0]      frame_period = 24'h000008;
    logic                            frame_done;
    logic                            frame_start;
    logic                            frame_trig_drop;
    iatc_pkg::iatc_state_e           acq_status;
    logic [iatc_pkg::CNT_W-1:0]      frame_cnt;
    iatc_pkg::iatc_scheme_e          scheme_active;
    int                              bad_count = 0;
    int                              n_tests = 0;
    int                              gap;

    ////////////////////////////////////////////////////////////////////////////
    // Clock, design and far side
    always #2 sys_clk = ~sys_clk;

    iatc_ctrl uut (.sys_clk(sys_clk), .rstn(rstn), .acq_start_cmd(acq_start_cmd), .acq_stop_cmd(acq_stop_cmd),
        .acq_mode(acq_mode), .scheme_we(scheme_we), .control_scheme_select(scheme_sel), .trig_sel(trig_sel),
        .trig_cfg_we(trig_cfg_we), .trig_cfg_wdata(trig_cfg_wdata), .sw_trig_cmd(sw_trig_cmd),
        .line1_in(line1_in), .frame_count(frame_count), .frame_period(frame_period), .frame_done(frame_done),
        .frame_start(frame_start), .frame_trig_drop(frame_trig_drop), .acq_status(acq_status),
        .frame_cnt(frame_cnt), .scheme_active(scheme_active));

    iatc_partner u_partner (.sys_clk(sys_clk), .rstn(rstn), .frame_start(frame_start), .line_fire(line_fire),
        .frame_done(frame_done), .line1_in(line1_in));

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers: compare, one-cycle strobes, bounded waits
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
            bad_count++;
        end
    endtask

    task automatic do_start();
        @(posedge sys_clk); acq_start_cmd <= 1'b1;
        @(posedge sys_clk); acq_start_cmd <= 1'b0;
        #1;
    endtask

    task automatic do_stop();
        @(posedge sys_clk); acq_stop_cmd <= 1'b1;
        @(posedge sys_clk); acq_stop_cmd <= 1'b0;
        #1;
    endtask

    task automatic do_sw(input iatc_pkg::iatc_sel_e s);
        @(posedge sys_clk); sw_trig_cmd <= 1'b1; trig_sel <= s;
        @(posedge sys_clk); sw_trig_cmd <= 1'b0;
        #1;
    endtask

    task automatic do_cfg(input iatc_pkg::iatc_sel_e s, input logic on, input iatc_pkg::iatc_src_e src);
        @(posedge sys_clk); trig_cfg_we <= 1'b1; trig_sel <= s; trig_cfg_wdata <= '{mode_on: on, src: src};
        @(posedge sys_clk); trig_cfg_we <= 1'b0;
    endtask

    task automatic do_scheme(input iatc_pkg::iatc_scheme_e s);
        @(posedge sys_clk); scheme_we <= 1'b1; scheme_sel <= s;
        @(posedge sys_clk); scheme_we <= 1'b0;
        @(posedge sys_clk); #1;
    endtask

    task automatic wait_st(input iatc_pkg::iatc_state_e s, input string nm);
        for (int i = 0; i < 40 && acq_status !== s; i++) begin
            @(posedge sys_clk); #1;
        end
        check(nm, s, acq_status);
    endtask

    task automatic wait_fs(output int n);
        n = 0;
        do begin
            @(posedge sys_clk); #1; n++;
        end while (frame_start !== 1'b1 && n < 60);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        check("status after reset", iatc_pkg::IATC_IDLE, acq_status);
        check("count after reset", 0, frame_cnt);
        check("scheme after reset", iatc_pkg::IATC_LEGACY, scheme_active);
    endtask

    task automatic t_legacy_single();
        do_cfg(iatc_pkg::IATC_SEL_FRAME, 1'b1, iatc_pkg::IATC_SRC_SOFTWARE);
        do_sw(iatc_pkg::IATC_SEL_FRAME);
        check("drop before start", 1, frame_trig_drop);
        check("no frame before start", 0, frame_start);
        do_start();
        check("legacy start status", iatc_pkg::IATC_WAIT_FRAME, acq_status);
        do_sw(iatc_pkg::IATC_SEL_ACQ);
        check("legacy frame start", 1, frame_start);
        check("frame status", iatc_pkg::IATC_FRAME, acq_status);
        check("count one", 1, frame_cnt);
        wait_st(iatc_pkg::IATC_IDLE, "single lapses");
        do_sw(iatc_pkg::IATC_SEL_FRAME);
        check("no second single frame", 0, frame_start);
    endtask

    task automatic t_standard_burst();
        do_scheme(iatc_pkg::IATC_STANDARD);
        check("scheme switched", iatc_pkg::IATC_STANDARD, scheme_active);
        do_cfg(iatc_pkg::IATC_SEL_ACQ, 1'b1, iatc_pkg::IATC_SRC_LINE1);
        acq_mode <= iatc_pkg::IATC_CONTINUOUS;
        do_start();
        check("burst wait", iatc_pkg::IATC_WAIT_ACQ, acq_status);
        do_sw(iatc_pkg::IATC_SEL_FRAME);
        check("frame ignored in burst wait", 0, frame_start);
        check("drop in burst wait", 1, frame_trig_drop);
        @(posedge sys_clk); line_fire <= 1'b1;
        @(posedge sys_clk); line_fire <= 1'b0;
        wait_st(iatc_pkg::IATC_WAIT_FRAME, "line burst trigger");
        do_sw(iatc_pkg::IATC_SEL_FRAME);
        check("burst frame one", 1, frame_start);
        wait_st(iatc_pkg::IATC_WAIT_FRAME, "ready again");
        do_sw(iatc_pkg::IATC_SEL_FRAME);
        check("count two", 2, frame_cnt);
        wait_st(iatc_pkg::IATC_WAIT_ACQ, "burst complete");
        check("count cleared", 0, frame_cnt);
        do_stop();
        check("stop when waiting", iatc_pkg::IATC_IDLE, acq_status);
    endtask

    task automatic t_internal_stop();
        do_scheme(iatc_pkg::IATC_LEGACY);
        do_cfg(iatc_pkg::IATC_SEL_FRAME, 1'b0, iatc_pkg::IATC_SRC_SOFTWARE);
        do_start();
        check("no burst in legacy", iatc_pkg::IATC_WAIT_FRAME, acq_status);
        wait_fs(gap);
        wait_fs(gap);
        check("internal period", 8, gap);
        do_stop();
        check("stop mid frame", iatc_pkg::IATC_FRAME, acq_status);
        wait_st(iatc_pkg::IATC_IDLE, "frame finished then idle");
        wait_fs(gap);
        check("no frame after stop", 60, gap);
    endtask

    task automatic t_sources();
        do_scheme(iatc_pkg::IATC_STANDARD);
        do_cfg(iatc_pkg::IATC_SEL_ACQ, 1'b1, iatc_pkg::IATC_SRC_SOFTWARE);
        do_cfg(iatc_pkg::IATC_SEL_FRAME, 1'b1, iatc_pkg::IATC_SRC_LINE1);
        do_start();
        check("software burst wait", iatc_pkg::IATC_WAIT_ACQ, acq_status);
        do_sw(iatc_pkg::IATC_SEL_ACQ);
        check("software burst trigger", iatc_pkg::IATC_WAIT_FRAME, acq_status);
        @(posedge sys_clk); line_fire <= 1'b1;
        @(posedge sys_clk); line_fire <= 1'b0;
        #1;
        wait_fs(gap);
        check("line frame start", 1, frame_start);
        wait_st(iatc_pkg::IATC_WAIT_FRAME, "line frame done");
        do_stop();
        check("stop after line frame", iatc_pkg::IATC_IDLE, acq_status);
        do_cfg(iatc_pkg::IATC_SEL_ACQ, 1'b0, iatc_pkg::IATC_SRC_SOFTWARE);
        do_start();
        check("burst enable internal", iatc_pkg::IATC_WAIT_FRAME, acq_status);
        do_stop();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Verdict, main sequence and watchdog
    task automatic finish_test();
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk); #1;
        t_reset();
        t_legacy_single();
        t_standard_burst();
        t_internal_stop();
        t_sources();
        finish_test();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        finish_test();
    end
endmodule
